/* File: verilog/cfg_pin_pkg.sv */
package cfg_pin_pkg;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int CODE_W    = 12;
    localparam int SREG_N    = 4;
    localparam int SADDR_W   = 4;
    localparam int FRAME_W   = 16;
    localparam int PIN_N     = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] SREG_OFS   = 8'h10;

    // control register bits (write 1 to act)
    localparam int CTRL_SCLR_BIT = 0;
    localparam int CTRL_ECLR_BIT = 1;

    // status register bits
    localparam int ST_MODE_BIT = 0;
    localparam int ST_FMT_BIT  = 1;
    localparam int ST_OEA_BIT  = 2;
    localparam int ST_OEB_BIT  = 3;
    localparam int ST_PD_BIT   = 4;
    localparam int ST_ERR_BIT  = 5;
    localparam int ST_BUSY_BIT = 6;

    // serial register 0 fields
    localparam int SF_FMT_BIT = 0;
    localparam int SF_OEA_BIT = 1;
    localparam int SF_PD_BIT  = 2;

    localparam logic [CODE_W-1:0] SREG_RESET  = 12'h000;
    localparam logic [4:0]        FRAME_BITS  = 5'h10;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    // synchronised pin vector positions
    localparam int PIN_SEL = 0;
    localparam int PIN_FMT = 1;
    localparam int PIN_OEA = 2;
    localparam int PIN_PD  = 3;
    localparam int PIN_OEB = 4;
    localparam logic [PIN_N-1:0] PIN_RESET = 5'h00;

    typedef enum logic [1:0] {
        SH_IDLE  = 2'b00,
        SH_SHIFT = 2'b01,
        SH_FULL  = 2'b10
    } shift_state_t;
endpackage

/* File: verilog/serial_port_if.sv */
`timescale 1ns/1ps
interface serial_port_if;
    import cfg_pin_pkg::*;
    logic                clk_rise;
    logic                enable_n;
    logic                data_bit;
    logic                clear;
    logic                wr_stb;
    logic [SADDR_W-1:0]  wr_addr;
    logic [CODE_W-1:0]   wr_data;
    logic                frame_err;
    logic                busy;
    modport host    (output clk_rise, enable_n, data_bit, clear,
                     input wr_stb, wr_addr, wr_data, frame_err, busy);
    modport shifter (input clk_rise, enable_n, data_bit, clear,
                     output wr_stb, wr_addr, wr_data, frame_err, busy);
endinterface

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
    import cfg_pin_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [PIN_N-1:0] pins_in,
    output logic      [PIN_N-1:0] pins_out
);
    // first stage feeds only the second stage
    logic [PIN_N-1:0] meta_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r   <= PIN_RESET;
            pins_out <= PIN_RESET;
        end else begin
            meta_r   <= pins_in;
            pins_out <= meta_r;
        end
    end
endmodule

/* File: verilog/serial_shifter.sv */
`timescale 1ns/1ps
module serial_shifter
    import cfg_pin_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    serial_port_if.shifter sp
);
    shift_state_t       state_r;
    logic [FRAME_W-1:0] shift_r;
    logic [4:0]         cnt_r;

    assign sp.busy = (state_r != SH_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn || sp.clear) begin
            state_r      <= SH_IDLE;
            shift_r      <= '0;
            cnt_r        <= '0;
            sp.wr_stb    <= 1'b0;
            sp.frame_err <= 1'b0;
            sp.wr_addr   <= '0;
            sp.wr_data   <= '0;
        end else begin
            sp.wr_stb    <= 1'b0;
            sp.frame_err <= 1'b0;
            unique case (state_r)
                SH_IDLE: begin
                    cnt_r <= '0;
                    if (!sp.enable_n) begin
                        state_r <= SH_SHIFT;
                    end
                end
                SH_SHIFT: begin
                    // frame closed before all bits arrived: dropped
                    if (sp.enable_n) begin
                        sp.frame_err <= 1'b1;
                        state_r      <= SH_IDLE;
                    end else if (sp.clk_rise) begin
                        shift_r <= {shift_r[FRAME_W-2:0], sp.data_bit};
                        cnt_r   <= cnt_r + 5'h01;
                        if (cnt_r == FRAME_BITS - 5'h01) begin
                            state_r <= SH_FULL;
                        end
                    end
                end
                SH_FULL: begin
                    // extra clocks after a full word are ignored
                    if (sp.enable_n) begin
                        sp.wr_stb  <= 1'b1;
                        sp.wr_addr <= shift_r[FRAME_W-1:CODE_W];
                        sp.wr_data <= shift_r[CODE_W-1:0];
                        state_r    <= SH_IDLE;
                    end
                end
                default: begin
                    state_r <= SH_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: verilog/config_pin_serial_select.sv */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// RULE1: select low: shared pins are format, channel A enable, power-down.
// RULE2: select high: shared pins form the serial write port into registers.
// RULE3: parallel format pin high gives two's complement, low offset binary.
// RULE4: parallel channel A enable pin low drives outputs, high floats them.
// RULE5: channel B enable pin low drives, high floats, in either mode.
// RULE6: parallel power-down pin low runs normally, high powers down.
// RULE7: a low pulse on select clears the serial registers.
// RULE8: in serial mode shared pin activity never acts as parallel controls.
module config_pin_serial_select
    import cfg_pin_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // configuration pins
    input  wire logic              interface_select,
    input  wire logic              format_select,
    input  wire logic              oe_a_n,
    input  wire logic              power_down_control,
    input  wire logic              oe_b_n,
    // converter core codes, offset binary, same clock
    input  wire logic [CODE_W-1:0] core_code_a,
    input  wire logic [CODE_W-1:0] core_code_b,
    // channel outputs
    output logic [CODE_W-1:0]      data_a_o,
    output logic                   data_a_oe,
    output logic [CODE_W-1:0]      data_b_o,
    output logic                   data_b_oe,
    output logic                   power_down,
    output logic                   twos_complement,
    output logic                   serial_mode
);
    function automatic logic [CODE_W-1:0] recode(
        input logic [CODE_W-1:0] code,
        input logic              twos
    );
        recode = {code[CODE_W-1] ^ twos, code[CODE_W-2:0]};
    endfunction

    // register index of a byte address (3 for every serial register), or -1 when unmapped
    function automatic int reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = -1;
        if (addr == CTRL_OFS) begin
            reg_index = 0;
        end else if (addr == STATUS_OFS) begin
            reg_index = 1;
        end else if (addr == COUNT_OFS) begin
            reg_index = 2;
        end else if (addr[ADDR_W-1:4] == SREG_OFS[ADDR_W-1:4]
                     && addr[1:0] == 2'h0) begin
            reg_index = 3;
        end
    endfunction

    serial_port_if sp ();

    logic [PIN_N-1:0]  pins_s;
    logic              sclk_d_r;
    logic [CODE_W-1:0] sreg_r [SREG_N];
    logic              sreg_clear;
    logic              sclr_req_r;
    logic              frame_err_r;
    logic [15:0]       frame_cnt_r;

    logic              aw_hold_r;
    logic              w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0]        wstrb_r;
    logic              wr_fire;
    logic              eclr_fire;
    int                wr_idx;
    int                rd_idx;

    logic              sel;
    logic              fmt_nxt;
    logic              oea_n_nxt;
    logic              pd_nxt;

    pin_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pins_in  ({oe_b_n, power_down_control, oe_a_n,
                    format_select, interface_select}),
        .pins_out (pins_s)
    );

    assign sel = pins_s[PIN_SEL];

    // serial port only sees enable and clock while select is high; the data pin is not gated
    assign sp.enable_n = sel ? pins_s[PIN_FMT] : 1'b1; // RULE1 RULE2
    assign sp.clk_rise = sel & pins_s[PIN_OEA] & ~sclk_d_r; // RULE2
    assign sp.data_bit = pins_s[PIN_PD]; // RULE2
    assign sp.clear    = sreg_clear;

    serial_shifter u_shift (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sp      (sp.shifter)
    );

    // select low holds the serial side in reset
    assign sreg_clear = ~sel | sclr_req_r; // RULE7

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= pins_s[PIN_OEA];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || sreg_clear) begin
            for (int i = 0; i < SREG_N; i++) begin
                sreg_r[i] <= SREG_RESET; // RULE7
            end
        end else if (sp.wr_stb && sp.wr_addr < SADDR_W'(SREG_N)) begin
            sreg_r[sp.wr_addr[1:0]] <= sp.wr_data; // RULE2
        end
    end

    // effective controls: pins in parallel mode, registers in serial mode
    always_comb begin
        if (sel) begin
            fmt_nxt   = sreg_r[0][SF_FMT_BIT]; // RULE8
            oea_n_nxt = sreg_r[0][SF_OEA_BIT]; // RULE8
            pd_nxt    = sreg_r[0][SF_PD_BIT]; // RULE8
        end else begin
            fmt_nxt   = pins_s[PIN_FMT]; // RULE1 RULE3
            oea_n_nxt = pins_s[PIN_OEA]; // RULE1 RULE4
            pd_nxt    = pins_s[PIN_PD]; // RULE1 RULE6
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            twos_complement <= 1'b0;
            data_a_oe       <= 1'b0;
            data_b_oe       <= 1'b0;
            power_down      <= 1'b0;
            serial_mode     <= 1'b0;
        end else begin
            twos_complement <= fmt_nxt; // RULE3
            data_a_oe       <= ~oea_n_nxt; // RULE4
            data_b_oe       <= ~pins_s[PIN_OEB]; // RULE5
            power_down      <= pd_nxt; // RULE6
            serial_mode     <= sel;
        end
    end

    // powered down: codes freeze rather than toggle the output bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_a_o <= '0;
            data_b_o <= '0;
        end else if (!pd_nxt) begin
            data_a_o <= recode(core_code_a, fmt_nxt); // RULE3
            data_b_o <= recode(core_code_b, fmt_nxt); // RULE3
        end
    end

    // ---- axi4-lite write path ----
    assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    assign wr_idx  = reg_index(awaddr_r);
    assign eclr_fire = wr_fire && wr_idx == 0 && wstrb_r[0]
                       && wdata_r[CTRL_ECLR_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r     <= 1'b0;
            s_axi_awready <= 1'b0;
            awaddr_r      <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r     <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_r      <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_hold_r     <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!aw_hold_r) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r     <= 1'b0;
            s_axi_wready <= 1'b0;
            wdata_r      <= '0;
            wstrb_r      <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r     <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_hold_r     <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!w_hold_r) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx < 0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // software clear of the serial registers, one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclr_req_r <= 1'b0;
        end else begin
            sclr_req_r <= wr_fire && wr_idx == 0 && wstrb_r[0]
                          && wdata_r[CTRL_SCLR_BIT];
        end
    end

    // a new error in the clearing cycle survives the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_err_r <= 1'b0;
        end else if (sp.frame_err) begin
            frame_err_r <= 1'b1;
        end else if (eclr_fire) begin
            frame_err_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_cnt_r <= '0;
        end else if (sp.wr_stb) begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
        end
    end

    // ---- axi4-lite read path ----
    assign rd_idx = reg_index(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= (rd_idx < 0) ? RESP_SLVERR : RESP_OKAY;
            s_axi_rdata   <= '0;
            unique case (rd_idx)
                1: begin
                    s_axi_rdata[ST_MODE_BIT] <= serial_mode;
                    s_axi_rdata[ST_FMT_BIT]  <= twos_complement;
                    s_axi_rdata[ST_OEA_BIT]  <= data_a_oe;
                    s_axi_rdata[ST_OEB_BIT]  <= data_b_oe;
                    s_axi_rdata[ST_PD_BIT]   <= power_down;
                    s_axi_rdata[ST_ERR_BIT]  <= frame_err_r;
                    s_axi_rdata[ST_BUSY_BIT] <= sp.busy;
                end
                2: begin
                    s_axi_rdata[15:0] <= frame_cnt_r;
                end
                3: begin
                    s_axi_rdata[CODE_W-1:0] <= sreg_r[s_axi_araddr[3:2]];
                end
                default: begin
                    s_axi_rdata <= '0;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

/* File: testbench/cfg_pin_monitor.sv */
`timescale 1ns/1ps
module cfg_pin_monitor
    import cfg_pin_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              interface_select,
    input wire logic              format_select,
    input wire logic              oe_a_n,
    input wire logic              power_down_control,
    input wire logic              oe_b_n,
    input wire logic [CODE_W-1:0] core_code_a,
    input wire logic [CODE_W-1:0] data_a_o,
    input wire logic [CODE_W-1:0] core_code_b,
    input wire logic [CODE_W-1:0] data_b_o,
    input wire logic              data_a_oe,
    input wire logic              data_b_oe,
    input wire logic              power_down,
    input wire logic              twos_complement,
    input wire logic              serial_mode
);
    logic [1:0] up_r;
    logic [3:0] quiet_r;

    // pin history means nothing until three edges after reset
    always_ff @(posedge aclk) begin
        if (!aresetn)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end
    // enable idle and no bus write: serial settings must sit still
    always_ff @(posedge aclk) begin
        if (!aresetn || !format_select || s_axi_awvalid)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hF)
            quiet_r <= quiet_r + 4'h1;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    mode_track_a:
    assert property (up_r == 2'h3 |->
        serial_mode == $past(interface_select, 3))
        else $error("mode does not follow select");
    fmt_par_a:
    assert property (up_r == 2'h3 && !serial_mode |->
        twos_complement == $past(format_select, 3))
        else $error("coding does not follow format pin");
    oea_par_a:
    assert property (up_r == 2'h3 && !serial_mode |->
        data_a_oe == !$past(oe_a_n, 3))
        else $error("channel a enable wrong");
    oeb_any_a:
    assert property (up_r == 2'h3 |-> data_b_oe == !$past(oe_b_n, 3))
        else $error("channel b enable wrong");
    pd_par_a:
    assert property (up_r == 2'h3 && !serial_mode |->
        power_down == $past(power_down_control, 3))
        else $error("power down does not follow pin");
    code_recode_a:
    assert property (up_r == 2'h3 && !power_down |->
        data_a_o == {$past(core_code_a[CODE_W-1]) ^ twos_complement,
                     $past(core_code_a[CODE_W-2:0])})
        else $error("channel a code not recoded");
    code_b_recode_a:
    assert property (up_r == 2'h3 && !power_down |->
        data_b_o == {$past(core_code_b[CODE_W-1]) ^ twos_complement,
                     $past(core_code_b[CODE_W-2:0])})
        else $error("channel b code not recoded");
    sel_clear_a:
    assert property (up_r == 2'h3 && $rose(serial_mode) |->
        !twos_complement && data_a_oe && !power_down)
        else $error("select pulse did not clear settings");
    serial_hold_a:
    assert property (quiet_r == 4'hF && serial_mode && $past(serial_mode) |->
        $stable(power_down) && $stable(twos_complement) && $stable(data_a_oe))
        else $error("shared pins acted as parallel controls");

    cover property ($rose(serial_mode));
    cover property (serial_mode && $rose(power_down));
    cover property (serial_mode && $fell(data_b_oe));
endmodule

bind config_pin_serial_select cfg_pin_monitor u_mon (
    .aclk, .aresetn, .s_axi_awvalid, .interface_select, .format_select,
    .oe_a_n, .power_down_control, .oe_b_n, .core_code_a, .data_a_o,
    .core_code_b, .data_b_o,
    .data_a_oe, .data_b_oe, .power_down, .twos_complement, .serial_mode
);

/* File: testbench/cfg_host_model.sv */
`timescale 1ns/1ps
module cfg_host_model (
    input  wire logic aclk,
    output logic      interface_select,
    output logic      format_select,
    output logic      oe_a_n,
    output logic      power_down_control,
    output logic      oe_b_n
);
    // 4 edges per level, above what the 2-flop pin sync needs
    localparam int HOLD = 4;

    initial begin
        {interface_select, format_select, oe_a_n} = 3'h0;
        {power_down_control, oe_b_n} = 2'h0;
    end

    task automatic hold_n();
        repeat (HOLD) @(posedge aclk);
    endtask

    // v = {select, chan b off, power down, chan a off, format}
    task automatic set_par(input logic [4:0] v);
        interface_select   <= v[4];
        oe_b_n             <= v[3];
        power_down_control <= v[2];
        oe_a_n             <= v[1];
        format_select      <= v[0];
        hold_n();
    endtask

    // clock idles low outside frames; msb first
    task automatic frame(input logic [15:0] w, input int nbits);
        format_select <= 1'b0;
        hold_n();
        for (int i = 0; i < nbits; i++) begin
            power_down_control <= w[15-i];
            oe_a_n             <= 1'b0;
            hold_n();
            oe_a_n <= 1'b1;
            hold_n();
        end
        oe_a_n <= 1'b0;
        hold_n();
        format_select      <= 1'b1;
        // released data line must not keep showing the last bit
        power_down_control <= ~power_down_control;
        hold_n();
    endtask

    task automatic wiggle();
        repeat (4) begin
            oe_a_n             <= ~oe_a_n;
            power_down_control <= ~power_down_control;
            hold_n();
        end
    endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import cfg_pin_pkg::*;

    typedef struct packed {
        logic [1:0]        resp;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mask;
    } note_t;

    logic              aclk = 1'b0;
    logic              aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [CODE_W-1:0] core_code_a, core_code_b;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic              s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    wire logic [CODE_W-1:0] data_a_o, data_b_o;
    wire logic         data_a_oe, data_b_oe, power_down;
    wire logic         twos_complement, serial_mode;
    wire logic         interface_select, format_select, oe_a_n;
    wire logic         power_down_control, oe_b_n;
    logic [33:0]       got;
    note_t             cur;
    note_t             notes[$];
    int                errors = 0;
    int                cmp_count = 0;

    always #2 aclk = ~aclk;

    config_pin_serial_select u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .interface_select,
        .format_select, .oe_a_n, .power_down_control, .oe_b_n,
        .core_code_a, .core_code_b, .data_a_o, .data_a_oe,
        .data_b_o, .data_b_oe, .power_down, .twos_complement,
        .serial_mode
    );
    cfg_host_model u_host (
        .aclk, .interface_select, .format_select, .oe_a_n,
        .power_down_control, .oe_b_n
    );

    always @(posedge aclk) begin
        core_code_a <= 12'($urandom);
        core_code_b <= 12'($urandom);
    end

    // random stalls; once up, a ready holds until its valid is seen
    always @(posedge aclk) begin
        if (!s_axi_rready || s_axi_rvalid)
            s_axi_rready <= 1'($urandom);
        if (!s_axi_bready || s_axi_bvalid)
            s_axi_bready <= 1'($urandom);
    end

    // an answer counts only at the edge where valid meets ready
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready
            || s_axi_bvalid && s_axi_bready) begin
            cur = notes.pop_front();
            got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata & cur.mask}
                               : {s_axi_bresp, 32'h0};
            cmp_count++;
            if (got !== {cur.resp, cur.data & cur.mask}) begin
                errors++;
                $display("wrong value at %0t: got %h expected %h", $time,
                         got, {cur.resp, cur.data & cur.mask});
            end
        end
    end

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [DATA_W-1:0] m, input logic [1:0] r);
        notes.push_back('{r, d, m});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!(s_axi_rvalid && s_axi_rready));
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [1:0] r, input logic [3:0] s = 4'hF);
        logic aw;
        logic w;
        notes.push_back('{r, 32'h0, 32'h0});
        aw = 1'b1;
        w  = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w  = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid  <= w;
        end
        do @(posedge aclk); while (!(s_axi_bvalid && s_axi_bready));
    endtask

    // busy bit is left out: its timing is free
    task automatic st(input logic [DATA_W-1:0] e);
        rd(STATUS_OFS, e, 32'h3F, RESP_OKAY);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // the run takes about 1000 edges
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        complete_run();
    end

    initial begin
        logic [3:0] r;
        logic [3:0] v;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {core_code_a, core_code_b} = 24'h0;
        void'($urandom(32'hCF41));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.set_par(5'h00);
        st(32'h0C);
        rd(SREG_OFS, 32'h0, 32'hFFF, RESP_OKAY);
        rd(8'h20, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(8'h24, 32'h0, RESP_SLVERR);
        wr(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        st(32'h0C);
        $display("test done: reset values and map");
        r = 4'($urandom);
        for (int i = 0; i < 16; i++) begin
            v = 4'(i) ^ r;
            u_host.set_par({1'b0, v});
            st(32'({v[2], ~v[3], ~v[1], v[0], 1'b0}));
        end
        $display("test done: parallel pins");
        u_host.set_par(5'h11);
        st(32'h0D);
        u_host.frame(16'h0005, 16);
        repeat (8) @(posedge aclk);
        st(32'h1F);
        rd(SREG_OFS, 32'h5, 32'hFFF, RESP_OKAY);
        rd(COUNT_OFS, 32'h1, 32'hFFFF, RESP_OKAY);
        u_host.wiggle();
        st(32'h1F);
        u_host.frame(16'h2ABC, 16);
        repeat (8) @(posedge aclk);
        u_host.frame(16'h0002, 8);
        repeat (8) @(posedge aclk);
        rd(SREG_OFS + 8'h08, 32'hABC, 32'hFFF, RESP_OKAY);
        st(32'h3F);
        wr(CTRL_OFS, 32'h2, RESP_OKAY, 4'hE);
        st(32'h3F);
        wr(CTRL_OFS, 32'h2, RESP_OKAY);
        u_host.frame(16'h0002, 16);
        u_host.set_par(5'h19);
        st(32'h01);
        wr(CTRL_OFS, 32'h1, RESP_OKAY);
        rd(SREG_OFS, 32'h0, 32'hFFF, RESP_OKAY);
        u_host.frame(16'h0004, 16);
        repeat (8) @(posedge aclk);
        u_host.set_par(5'h08);
        u_host.set_par(5'h11);
        rd(SREG_OFS, 32'h0, 32'hFFF, RESP_OKAY);
        st(32'h0D);
        $display("test done: serial port");
        u_host.set_par(5'h07);
        st(32'h1A);
        $display("test done: back to parallel");
        complete_run();
    end
endmodule
